// file: rtl/geiu_pkg.sv
// Constants and types shared by the gpio edge interrupt unit
// Operation
// - Ten pins, each with own direction bit
// - Outputs drive data; reads return pin level
// - Every pin level feeds the edge logic
// - Pins, overload, adc ready, touch sense interrupt
// - Rise and fall enable registers pick edges
// - Status readable; writing one clears bit
// - Edge capture needs no link clock
// - Interrupt pin is OR of status
// - Forwarding copies interrupt into slot twelve
// - Stopped link: forward by raising data in
// - Input overload sets the overload flag
// - Overload edges interrupt when enabled
// - Headphone clip sets left, right, ground flags
// - Clip edge sets summary status and interrupt
// - Hold data in high until sync high-low
`default_nettype none
package geiu_pkg;
    localparam int PINS = 10;
    localparam int WORD = 16;
    localparam int IDXW = 7;

    localparam logic [6:0] IDX_PIN_VALUE = 7'h5A;
    localparam logic [6:0] IDX_PIN_DIR   = 7'h5C;
    localparam logic [6:0] IDX_RISE_EN   = 7'h5E;
    localparam logic [6:0] IDX_FALL_EN   = 7'h60;
    localparam logic [6:0] IDX_STATUS    = 7'h62;
    localparam logic [6:0] IDX_FEATURE   = 7'h6A;
    localparam logic [6:0] IDX_CLIP      = 7'h70;

    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [9:0]  RST_OE_B = 10'h3FF;

    // Status and edge enable bit positions
    localparam int SB_ADC  = 11;
    localparam int SB_TXP  = 12;
    localparam int SB_TXM  = 13;
    localparam int SB_CLIP = 14;
    localparam int SB_OVL  = 15;

    // Feature register bits
    localparam int FB_INPUT_OVERLOAD_FLAG = 0;
    localparam int FB_FWD  = 1;
    localparam int FB_HEADPHONE_DRIVE_EN = 5;

    // Neighbour inputs, in port order
    localparam int NSRC   = 7;
    localparam int NB_ADC = 0;
    localparam int NB_TXP = 1;
    localparam int NB_TXM = 2;
    localparam int NB_OVL = 3;
    localparam int NB_CL  = 4;
    localparam int NB_CG  = 6;

    // Frame layout, positions counted from the sync rise
    localparam logic [7:0] POS_S0_END = 8'h0F;
    localparam logic [7:0] POS_S1_END = 8'h23;
    localparam logic [7:0] POS_S2_END = 8'h37;
    localparam logic [7:0] POS_LAST   = 8'hFF;
    localparam logic [7:0] TAG_FRAME  = 8'h0F;
    localparam logic [7:0] TAG_S1     = 8'h0E;
    localparam logic [7:0] TAG_S2     = 8'h0D;
    localparam logic [7:0] TAG_S12    = 8'h03;
    localparam logic [1:0] ID_PRIMARY = 2'h0;
    localparam int RW_BIT  = 19;
    localparam int IDX_LSB = 12;
    localparam int DAT_LSB = 4;

    // Link clock watchdog
    localparam int MCLK_NS        = 10;
    localparam int BITCLK_STOP_NS = 320;
    localparam int STOP_CYC = (BITCLK_STOP_NS + MCLK_NS - 1) / MCLK_NS;

    typedef enum logic [1:0] {WK_IDLE, WK_HOLD, WK_SYNC_HI} geiu_wake_t;
endpackage
`default_nettype wire

// file: rtl/geiu_if.sv
// Signals passed between the link domain and the register domain
`timescale 1ns/1ps
`default_nettype none
interface geiu_if;
    logic        cmd_tgl;
    logic        cmd_wr;
    logic [6:0]  cmd_idx;
    logic [15:0] cmd_data;
    logic        alive_tgl;
    logic        ser;
    logic        rsp_tgl;
    logic [6:0]  rsp_idx;
    logic [15:0] rsp_data;
    logic        irq_lvl;
    logic        fwd_en;

    modport link (
        output cmd_tgl, cmd_wr, cmd_idx, cmd_data, alive_tgl, ser,
        input  rsp_tgl, rsp_idx, rsp_data, irq_lvl, fwd_en
    );
    modport core (
        input  cmd_tgl, cmd_wr, cmd_idx, cmd_data, alive_tgl, ser,
        output rsp_tgl, rsp_idx, rsp_data, irq_lvl, fwd_en
    );
endinterface
`default_nettype wire

// file: rtl/geiu_edge_det.sv
// Sticky edge detector for the interrupt sources
`timescale 1ns/1ps
`default_nettype none
module geiu_edge_det
#(
    parameter int W = 16
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Sources and controls
    input  wire logic [W-1:0] lvl,
    input  wire logic [W-1:0] rise_en,
    input  wire logic [W-1:0] fall_en,
    input  wire logic [W-1:0] clr,
    // Sticky status
    output logic      [W-1:0] sts
);
    typedef struct packed {
        logic         armed;
        logic [W-1:0] prev;
        logic [W-1:0] sts;
    } geiu_edge_t;

    geiu_edge_t q;
    geiu_edge_t d;
    logic [W-1:0] ev;

    // Runs on the crystal clock, so it keeps working while the link clock is off
    always_comb
    begin
        d = q;
        // First cycle after reset only learns levels, so a high source is no edge
        ev = '0;
        if (q.armed)
        begin
            ev = (lvl & ~q.prev & rise_en) | (~lvl & q.prev & fall_en);
        end
        d.armed = 1'b1;
        d.prev = lvl;
        // Set wins over a clear in the same cycle
        d.sts = (q.sts & ~clr) | ev;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign sts = q.sts;
endmodule
`default_nettype wire

// file: rtl/geiu_link.sv
// Link frame receiver and transmitter on the bit clock
`timescale 1ns/1ps
`default_nettype none
module geiu_link
(
    // Link clock and reset
    input  wire logic bit_clk,
    input  wire logic rst_b,
    // Link pins
    input  wire logic sync,
    input  wire logic sdata_out,
    // Register domain
    geiu_if.link      lk
);
    import geiu_pkg::*;

    typedef struct packed {
        logic        rs1;
        logic        rs2;
        logic        sync_p;
        logic [7:0]  cnt;
        logic [19:0] sh;
        logic [2:0]  tag;
        logic [1:0]  id;
        logic [19:0] s1;
        logic        cmd_tgl;
        logic        cmd_wr;
        logic [6:0]  cmd_idx;
        logic [15:0] cmd_data;
        logic        rt1;
        logic        rt2;
        logic        rt3;
        logic        pv;
        logic [6:0]  pidx;
        logic [15:0] pdata;
        logic        cv;
        logic [6:0]  cidx;
        logic [15:0] cdata;
        logic        ir1;
        logic        ir2;
        logic        fw1;
        logic        fw2;
        logic        alive;
        logic        ser;
    } geiu_link_t;

    geiu_link_t q;
    geiu_link_t d;
    logic       rise;
    logic [7:0] pos;

    // Value of outgoing bit at frame position p
    function automatic logic frame_bit(
        input logic [7:0]  p,
        input logic        v,
        input logic        f,
        input logic        i,
        input logic [6:0]  a,
        input logic [15:0] w
    );
        logic [7:0] b;
        b = '0;
        frame_bit = 1'b0;
        if (p <= POS_S0_END)
        begin
            b = POS_S0_END - p;
            frame_bit = (b == TAG_FRAME && (v || f)) || (b == TAG_S1 && v)
                     || (b == TAG_S2 && v) || (b == TAG_S12 && f);
        end
        else if (p <= POS_S1_END)
        begin
            b = POS_S1_END - p;
            if (b >= 8'(IDX_LSB) && b < 8'(IDX_LSB + IDXW))
            begin
                frame_bit = a[3'(b - 8'(IDX_LSB))];
            end
        end
        else if (p <= POS_S2_END)
        begin
            b = POS_S2_END - p;
            if (b >= 8'(DAT_LSB) && b < 8'(DAT_LSB + WORD))
            begin
                frame_bit = w[4'(b - 8'(DAT_LSB))];
            end
        end
        else if (p == POS_LAST)
        begin
            frame_bit = i && f;
        end
    endfunction

    always_comb
    begin
        d = q;
        d.rs1 = 1'b1;
        d.rs2 = q.rs1;
        d.sync_p = sync;
        d.alive = ~q.alive;
        d.rt1 = lk.rsp_tgl;
        d.rt2 = q.rt1;
        d.rt3 = q.rt2;
        d.ir1 = lk.irq_lvl;
        d.ir2 = q.ir1;
        d.fw1 = lk.fwd_en;
        d.fw2 = q.fw1;
        rise = sync & ~q.sync_p;
        pos = rise ? '0 : q.cnt;
        d.cnt = pos + 8'h01;
        d.sh = {q.sh[18:0], sdata_out};
        if (pos == POS_S0_END)
        begin
            d.tag = d.sh[15:13];
            d.id = d.sh[1:0];
        end
        if (pos == POS_S1_END)
        begin
            d.s1 = d.sh;
        end
        // Only primary frames with a valid address; writes also need valid data
        if (pos == POS_S2_END && q.tag[2] && q.tag[1] && q.id == ID_PRIMARY
            && (q.s1[RW_BIT] || q.tag[0]))
        begin
            d.cmd_tgl = ~q.cmd_tgl;
            d.cmd_wr = ~q.s1[RW_BIT];
            d.cmd_idx = q.s1[IDX_LSB +: IDXW];
            d.cmd_data = d.sh[DAT_LSB +: WORD];
        end
        // Read data waits for the next frame start
        if (q.rt2 != q.rt3)
        begin
            d.pv = 1'b1;
            d.pidx = lk.rsp_idx;
            d.pdata = lk.rsp_data;
        end
        if (rise)
        begin
            d.cv = q.pv;
            d.cidx = q.pidx;
            d.cdata = q.pdata;
            d.pv = q.rt2 != q.rt3;
        end
        d.ser = frame_bit(d.cnt, d.cv, q.fw2, q.ir2, d.cidx, d.cdata);
        if (!q.rs2)
        begin
            d = '0;
            d.rs1 = 1'b1;
            d.rs2 = q.rs1;
        end
    end

    always_ff @(posedge bit_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign lk.cmd_tgl = q.cmd_tgl;
    assign lk.cmd_wr = q.cmd_wr;
    assign lk.cmd_idx = q.cmd_idx;
    assign lk.cmd_data = q.cmd_data;
    assign lk.alive_tgl = q.alive;
    assign lk.ser = q.ser;
endmodule
`default_nettype wire

// file: rtl/geiu_top.sv
// Top of the gpio edge interrupt unit: registers, pins, sources, wake
`timescale 1ns/1ps
`default_nettype none
module geiu_top
#(
    parameter int BITCLK_STOP_CYC = geiu_pkg::STOP_CYC
)
(
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    // Link
    input  wire logic                      bit_clk,
    input  wire logic                      sync,
    input  wire logic                      sdata_out,
    output logic                           sdata_in,
    // General purpose pins
    input  wire logic [geiu_pkg::PINS-1:0] gpio_in,
    output logic      [geiu_pkg::PINS-1:0] gpio_out,
    output logic      [geiu_pkg::PINS-1:0] gpio_oe_b,
    // Neighbour sources
    input  wire logic                      adc_ready,
    input  wire logic                      touch_xplus_sense,
    input  wire logic                      touch_xminus_sense,
    input  wire logic                      overload_det,
    input  wire logic                      clip_left,
    input  wire logic                      clip_right,
    input  wire logic                      clip_ground,
    // Interrupt
    output logic                           irq_line_out
);
    import geiu_pkg::*;

    if (BITCLK_STOP_CYC < 2 || BITCLK_STOP_CYC > 255)
    begin : g_chk
        $error("BITCLK_STOP_CYC out of range");
    end

    typedef struct packed {
        logic            rr1;
        logic            rr2;
        logic [PINS-1:0] gs1;
        logic [PINS-1:0] gs2;
        logic [NSRC-1:0] ns1;
        logic [NSRC-1:0] ns2;
        logic            ys1;
        logic            ys2;
        logic            ct1;
        logic            ct2;
        logic            ct3;
        logic            at1;
        logic            at2;
        logic            at3;
        logic            ss1;
        logic            ss2;
        logic [7:0]      stop_cnt;
        logic            stopped;
        logic [PINS-1:0] pin_out;
        logic [PINS-1:0] oe_b;
        logic [WORD-1:0] rise_en;
        logic [WORD-1:0] fall_en;
        logic [WORD-1:0] feat;
        logic            input_overload_flag;
        logic [2:0]      clip;
        logic            rsp_tgl;
        logic [6:0]      rsp_idx;
        logic [WORD-1:0] rsp_data;
        logic            irq;
        geiu_wake_t      wake;
        logic            sdata;
    } geiu_core_t;

    geiu_core_t      q;
    geiu_core_t      d;
    logic [WORD-1:0] src;
    logic [WORD-1:0] sts;
    logic [WORD-1:0] clr;
    logic [WORD-1:0] rd;
    logic            cmd_ev;
    logic            wr_ev;

    geiu_if lk ();

    geiu_link u_link (
        .bit_clk   (bit_clk),
        .rst_b     (q.rr2),
        .sync      (sync),
        .sdata_out (sdata_out),
        .lk        (lk.link)
    );

    geiu_edge_det #(
        .W (WORD)
    ) u_edge (
        .clk     (mclk),
        .rst_b   (q.rr2),
        .lvl     (src),
        .rise_en (q.rise_en),
        .fall_en (q.fall_en),
        .clr     (clr),
        .sts     (sts)
    );

    always_comb
    begin
        d = q;
        clr = RST_WORD;
        rd = RST_WORD;
        src = RST_WORD;
        d.rr1 = 1'b1;
        d.rr2 = q.rr1;
        d.gs1 = gpio_in;
        d.gs2 = q.gs1;
        d.ns1 = {clip_ground, clip_right, clip_left, overload_det,
                 touch_xminus_sense, touch_xplus_sense, adc_ready};
        d.ns2 = q.ns1;
        d.ys1 = sync;
        d.ys2 = q.ys1;
        d.ct1 = lk.cmd_tgl;
        d.ct2 = q.ct1;
        d.ct3 = q.ct2;
        d.at1 = lk.alive_tgl;
        d.at2 = q.at1;
        d.at3 = q.at2;
        d.ss1 = lk.ser;
        d.ss2 = q.ss1;
        // Command fields are held steady by the link until the next frame
        cmd_ev = q.ct2 != q.ct3;
        wr_ev = cmd_ev && lk.cmd_wr;

        src[PINS-1:0] = q.gs2;
        src[SB_ADC] = q.ns2[NB_ADC];
        src[SB_TXP] = q.ns2[NB_TXP];
        src[SB_TXM] = q.ns2[NB_TXM];
        src[SB_CLIP] = q.feat[FB_HEADPHONE_DRIVE_EN] & (|q.ns2[NB_CG:NB_CL]);
        src[SB_OVL] = q.ns2[NB_OVL];

        // Watchdog: no toggle for a while means the link clock stopped
        if (q.at2 != q.at3)
        begin
            d.stop_cnt = '0;
            d.stopped = 1'b0;
        end
        else if (q.stop_cnt != 8'(BITCLK_STOP_CYC))
        begin
            d.stop_cnt = q.stop_cnt + 8'h01;
        end
        else
        begin
            d.stopped = 1'b1;
        end

        if (wr_ev)
        begin
            case (lk.cmd_idx)
                IDX_PIN_VALUE: d.pin_out = lk.cmd_data[PINS-1:0];
                IDX_PIN_DIR: d.oe_b = ~lk.cmd_data[PINS-1:0];
                IDX_RISE_EN: d.rise_en = lk.cmd_data;
                IDX_FALL_EN: d.fall_en = lk.cmd_data;
                IDX_STATUS: clr = lk.cmd_data;
                IDX_FEATURE: d.feat = lk.cmd_data;
                default: d.feat = q.feat;
            endcase
        end

        if (wr_ev && lk.cmd_idx == IDX_FEATURE && lk.cmd_data[FB_INPUT_OVERLOAD_FLAG])
        begin
            d.input_overload_flag = 1'b0;
        end
        if (q.ns2[NB_OVL])
        begin
            d.input_overload_flag = 1'b1;
        end
        // Clip flags clear together with the summary status bit
        if (clr[SB_CLIP])
        begin
            d.clip = '0;
        end
        if (q.feat[FB_HEADPHONE_DRIVE_EN])
        begin
            d.clip = d.clip | q.ns2[NB_CG:NB_CL];
        end

        case (lk.cmd_idx)
            IDX_PIN_VALUE: rd[PINS-1:0] = q.gs2;
            IDX_PIN_DIR: rd[PINS-1:0] = ~q.oe_b;
            IDX_RISE_EN: rd = q.rise_en;
            IDX_FALL_EN: rd = q.fall_en;
            IDX_STATUS: rd = sts;
            IDX_FEATURE:
            begin
                rd = q.feat;
                rd[FB_INPUT_OVERLOAD_FLAG] = q.input_overload_flag;
            end
            IDX_CLIP: rd[2:0] = q.clip;
            default: rd = RST_WORD;
        endcase
        if (cmd_ev && !lk.cmd_wr)
        begin
            d.rsp_tgl = ~q.rsp_tgl;
            d.rsp_idx = lk.cmd_idx;
            d.rsp_data = rd;
        end

        d.irq = |sts;

        case (q.wake)
            WK_IDLE:
            begin
                if (q.feat[FB_FWD] && q.stopped && q.irq)
                begin
                    d.wake = WK_HOLD;
                end
            end
            WK_HOLD:
            begin
                if (q.ys2)
                begin
                    d.wake = WK_SYNC_HI;
                end
            end
            WK_SYNC_HI:
            begin
                if (!q.ys2)
                begin
                    d.wake = WK_IDLE;
                end
            end
            default: d.wake = WK_IDLE;
        endcase
        // Low while stopped and idle so that a wake is a true rising edge
        d.sdata = (d.wake != WK_IDLE) | (q.ss2 & ~q.stopped);

        if (!q.rr2)
        begin
            d = '0;
            d.oe_b = RST_OE_B;
            d.rr1 = 1'b1;
            d.rr2 = q.rr1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.oe_b <= RST_OE_B;
        end
        else
        begin
            q <= d;
        end
    end

    assign lk.rsp_tgl = q.rsp_tgl;
    assign lk.rsp_idx = q.rsp_idx;
    assign lk.rsp_data = q.rsp_data;
    assign lk.irq_lvl = q.irq;
    assign lk.fwd_en = q.feat[FB_FWD];

    assign sdata_in = q.sdata;
    assign gpio_out = q.pin_out;
    assign gpio_oe_b = q.oe_b;
    assign irq_line_out = q.irq;
endmodule
`default_nettype wire

// file: bench/geiu_props.sv
// Port-level assertions for the gpio edge interrupt unit
`timescale 1ns/1ps
`default_nettype none
module geiu_props
#(
    parameter int BITCLK_STOP_CYC = 20
)
(
    // Clocks and reset
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic       bit_clk,
    // Link
    input wire logic       sync,
    input wire logic       sdata_out,
    input wire logic       sdata_in,
    // Pins
    input wire logic [9:0] gpio_in,
    input wire logic [9:0] gpio_out,
    input wire logic [9:0] gpio_oe_b,
    // Sources and interrupt
    input wire logic       adc_ready,
    input wire logic       touch_xplus_sense,
    input wire logic       touch_xminus_sense,
    input wire logic       overload_det,
    input wire logic       clip_left,
    input wire logic       clip_right,
    input wire logic       clip_ground,
    input wire logic       irq_line_out
);
    logic [16:0] src_q;
    logic        bc_q;
    logic [7:0]  stop_q;
    logic [7:0]  age_q;
    logic [10:0] lnk_q;
    wire logic [16:0] src = {gpio_in, adc_ready, touch_xplus_sense, touch_xminus_sense,
                             overload_det, clip_left, clip_right, clip_ground};

    // Saturating ages since link clock, sync or a source last moved
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            src_q  <= src;
            bc_q   <= 1'b0;
            stop_q <= 8'h00;
            age_q  <= 8'hFF;
            lnk_q  <= 11'h7FF;
        end
        else
        begin
            src_q  <= src;
            bc_q   <= bit_clk;
            stop_q <= (bit_clk != bc_q) ? 8'h00 : stop_q + {7'h00, stop_q != 8'hFF};
            age_q  <= (src != src_q) ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
            lnk_q  <= sync ? 11'h000 : lnk_q + {10'h000, lnk_q != 11'h7FF};
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_asleep;
        stop_q > BITCLK_STOP_CYC + 4;
    endsequence
    sequence s_wake;
        s_asleep ##0 $rose(sdata_in);
    endsequence

    a_reset_outs: assert property ($rose(rst_b) |-> gpio_oe_b == 10'h3FF && !irq_line_out)
        else $error("outputs not at reset values");
    a_irq_cause: assert property ($rose(irq_line_out) |-> age_q < 8'h0C)
        else $error("interrupt rose with no recent source edge");
    a_irq_clear: assert property ($fell(irq_line_out) |-> lnk_q < 11'h4B0)
        else $error("interrupt fell with no link write");
    a_dir_by_write: assert property ($changed(gpio_oe_b) |-> lnk_q < 11'h4B0)
        else $error("direction moved with no link write");
    a_out_by_write: assert property ($changed(gpio_out) |-> lnk_q < 11'h4B0)
        else $error("pin drive moved with no link write");
    a_wake_quiet: assert property (s_asleep and !irq_line_out |-> !sdata_in)
        else $error("data in high on a parked link with no interrupt");
    a_wake_hold: assert property (s_wake |=> sdata_in [*8])
        else $error("wake level dropped early");
    a_sdin_moves: assert property ($changed(sdata_in) |-> stop_q < 8'h08 || irq_line_out)
        else $error("data in moved on a parked link");
endmodule
bind geiu_top geiu_props #(.BITCLK_STOP_CYC(BITCLK_STOP_CYC)) u_props (
    .mclk(mclk), .rst_b(rst_b), .bit_clk(bit_clk), .sync(sync), .sdata_out(sdata_out),
    .sdata_in(sdata_in), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_b(gpio_oe_b),
    .adc_ready(adc_ready), .touch_xplus_sense(touch_xplus_sense),
    .touch_xminus_sense(touch_xminus_sense), .overload_det(overload_det),
    .clip_left(clip_left), .clip_right(clip_right), .clip_ground(clip_ground),
    .irq_line_out(irq_line_out));
`default_nettype wire

// file: bench/geiu_host.sv
// Link host model: sends command frames and captures the returned frame
`timescale 1ns/1ps
`default_nettype none
module geiu_host
(
    // Link
    input  wire logic bit_clk,
    input  wire logic sdata_in,
    output logic      sync,
    output logic      sdata_out
);
    logic [255:0] tx;
    logic [255:0] rx;

    initial
    begin
        sync      = 1'b0;
        sdata_out = 1'b0;
    end

    // Frame bit p sits at index 255-p; changes on the falling edge keep
    // them half a period clear of the rising-edge sampler
    task automatic frame(input logic wr, input logic [6:0] idx,
                         input logic [15:0] dat, input logic [1:0] id);
        tx          = '0;
        tx[255:240] = {2'b11, wr, 11'h000, id};
        tx[239:220] = {~wr, idx, 12'h000};
        tx[219:200] = {dat, 4'h0};
        for (int p = 0; p < 256; p++)
        begin
            @(negedge bit_clk);
            // Codec launches bit p one rising edge ahead, so it stands here
            rx[255-p] = sdata_in;
            sync      <= (p < 16);
            sdata_out <= tx[255-p];
        end
    endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the gpio edge interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import geiu_pkg::*;
    localparam int          STOPC = 20;
    localparam logic [15:0] RISE  = 16'hDAAA;
    localparam logic [15:0] FALL  = 16'h2155;
    logic        mclk    = 1'b0;
    logic        bit_clk = 1'b0;
    logic        bc_run  = 1'b1;
    logic        rst_b   = 1'b0;
    logic [9:0]  ext     = 10'h000;
    logic [6:0]  nb      = 7'h00;
    logic [15:0] lfsr    = 16'hE4F8;
    logic [9:0]  pins, gpio_out, gpio_oe_b;
    logic        sync, sdata_out, sdata_in, irq_line_out;
    logic [15:0] dir, val, s0, st, w;
    int          n_fail = 0;
    int          comparisons = 0;

    always #5 mclk = ~mclk;
    // A parked link clock rests low
    // Offset keeps the link clock out of step with the crystal clock
    initial
    begin
        #3.7;
        forever #80 if (bc_run || bit_clk) bit_clk = ~bit_clk;
    end
    assign pins = (gpio_oe_b & ext) | (~gpio_oe_b & gpio_out);

    geiu_top #(.BITCLK_STOP_CYC(STOPC)) DUT (
        .mclk(mclk), .rst_b(rst_b), .bit_clk(bit_clk), .sync(sync),
        .sdata_out(sdata_out), .sdata_in(sdata_in), .gpio_in(pins),
        .gpio_out(gpio_out), .gpio_oe_b(gpio_oe_b), .adc_ready(nb[0]),
        .touch_xplus_sense(nb[1]), .touch_xminus_sense(nb[2]), .overload_det(nb[3]),
        .clip_left(nb[4]), .clip_right(nb[5]), .clip_ground(nb[6]),
        .irq_line_out(irq_line_out));
    geiu_host host (.bit_clk(bit_clk), .sdata_in(sdata_in), .sync(sync),
                    .sdata_out(sdata_out));

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Sources in status bit order
    function automatic logic [15:0] srcv();
        return {nb[NB_OVL], |nb[NB_CG:NB_CL], nb[NB_TXM], nb[NB_TXP], nb[NB_ADC], 1'b0, pins};
    endfunction
    function automatic logic [15:0] edg(input logic [15:0] a, input logic [15:0] b);
        return (~a & b & RISE) | (a & ~b & FALL);
    endfunction
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] idx, input logic [15:0] d);
        host.frame(1'b1, idx, d, ID_PRIMARY);
    endtask
    // Answer returns a frame later; the filler frame names another codec
    task automatic rd(input logic [6:0] idx, input string nm, input logic [15:0] exp);
        host.frame(1'b0, idx, 16'h0000, ID_PRIMARY);
        host.frame(1'b0, 7'h00, 16'h0000, 2'h1);
        check(nm, host.rx[219:204], exp);
        check({nm, " idx"}, {9'h000, host.rx[238:232]}, {9'h000, idx});
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        repeat (80) @(negedge mclk);
        lfsr = nxt(lfsr);
        dir  = lfsr & 16'h03FF;
        lfsr = nxt(lfsr);
        val  = lfsr & 16'h03FF;
        wr(IDX_PIN_DIR, dir);
        wr(IDX_PIN_VALUE, val);
        @(negedge mclk);
        ext = ~lfsr[9:0];
        check("oe_b", {6'h00, gpio_oe_b}, {6'h00, ~dir[9:0]});
        check("drive", {6'h00, gpio_out & ~gpio_oe_b}, val & dir);
        rd(IDX_PIN_VALUE, "pin_value", (val & dir) | ({6'h00, ext} & ~dir));
        rd(7'h7E, "unmapped", 16'h0000);
        $display("pins test done");
        wr(IDX_RISE_EN, RISE);
        wr(IDX_FALL_EN, FALL);
        wr(IDX_FEATURE, 16'h0022);
        @(negedge mclk);
        s0  = srcv();
        ext = ~ext;
        nb  = 7'h1F;
        repeat (20) @(negedge mclk);
        st = edg(s0, srcv());
        check("irq_set", {15'h0000, irq_line_out}, {15'h0000, |st});
        s0 = srcv();
        nb = 7'h00;
        repeat (20) @(negedge mclk);
        st = st | edg(s0, srcv());
        rd(IDX_STATUS, "status", st);
        check("slot_irq", {14'h0000, host.rx[243], host.rx[0]}, 16'h0003);
        lfsr = nxt(lfsr);
        w    = st & lfsr & 16'hBFFF;
        wr(IDX_STATUS, w);
        st = st & ~w;
        rd(IDX_STATUS, "status_left", st);
        rd(IDX_CLIP, "clip_flags", 16'h0001);
        rd(IDX_FEATURE, "feature", 16'h0023);
        wr(IDX_STATUS, 16'hFFFF);
        check("irq_clear", {15'h0000, irq_line_out}, 16'h0000);
        $display("sources test done");
        bc_run = 1'b0;
        repeat (STOPC * 3) @(negedge mclk);
        check("sdin_idle", {15'h0000, sdata_in}, 16'h0000);
        nb[NB_ADC] = 1'b1;
        for (int i = 0; i < 100 && sdata_in !== 1'b1; i++)
            @(negedge mclk);
        check("irq_asleep", {15'h0000, irq_line_out}, 16'h0001);
        check("sdin_wake", {15'h0000, sdata_in}, 16'h0001);
        // A missed wake is already counted; skip the steps that depend on it
        if (sdata_in === 1'b1)
        begin
            repeat (200) @(negedge mclk);
            check("sdin_hold", {15'h0000, sdata_in}, 16'h0001);
            bc_run = 1'b1;
            host.frame(1'b0, 7'h00, 16'h0000, 2'h1);
            check("slot_wake", {15'h0000, host.rx[0]}, 16'h0001);
        end
        $display("wake test done");
        close_out();
    end
endmodule
`default_nettype wire
